// ===== pkg/iot_consts.vh
// register indices, field positions, reset values and mode codes of the io timer controls
`ifndef IOT_CONSTS_VH
`define IOT_CONSTS_VH

// register indices; the bus byte address is four times the index
`define IOT_IDX_GROUP03   30'h0080031d
`define IOT_IDX_CH4       30'h0080034a
`define IOT_IDX_CH5       30'h0080034b
`define IOT_IDX_CH6       30'h0080036a
`define IOT_IDX_CH7       30'h0080036b

// reset value of every control register
`define IOT_RESET_VAL     8'h00

// writable bit masks; unassigned bits read zero
`define IOT_MASK_GROUP03  8'h03
`define IOT_MASK_CH4      8'hff
`define IOT_MASK_CH5      8'hff
`define IOT_MASK_CH6      8'hff
`define IOT_MASK_CH7      8'h7f

// field positions (register bit 7 is the first printed bit of the byte)
`define IOT_GRP_CKS_HI    1
`define IOT_GRP_CKS_LO    0
`define IOT_CH4_CKS_HI    7
`define IOT_CH4_CKS_LO    6
`define IOT_CH4_EEN       5
`define IOT_CKS3_HI       7
`define IOT_CKS3_LO       5
`define IOT_CH7_CKS_HI    6
`define IOT_CH7_CKS_LO    5
`define IOT_ENS_HI        4
`define IOT_ENS_LO        3
`define IOT_MODE_HI       2
`define IOT_MODE_LO       0

// operating mode codes
`define IOT_MODE_SINGLE   3'h0
`define IOT_MODE_DELAYED  3'h1
`define IOT_MODE_CONT     3'h2
`define IOT_MODE_PWM      3'h3
`define IOT_MODE_MEAS_CLR 3'h4
`define IOT_MODE_MEAS_FR  3'h5

// ahb transfer type
`define IOT_HTRANS_NONSEQ 2'h2
`define IOT_HTRANS_SEQ    2'h3

`endif

// ===== rtl/iot_chan_mode.v
// mode decode and capture effects of one io timer channel
`timescale 1ns/100ps
`default_nettype none
`include "iot_consts.vh"

module iot_chan_mode (
	input  wire [2:0] mode,
	input  wire       ext_enable,
	input  wire       capture,
	output reg  [6:0] mode_onehot,
	output wire       measure_store,
	output wire       counter_reload
);

	// ==========================================
	// mode decode
	always @* begin
		mode_onehot = 7'h00;
		case (mode)
			`IOT_MODE_SINGLE:   mode_onehot = 7'h01; // RULE_05
			`IOT_MODE_DELAYED:  mode_onehot = 7'h02; // RULE_05
			`IOT_MODE_CONT:     mode_onehot = 7'h04; // RULE_05
			`IOT_MODE_PWM:      mode_onehot = 7'h08; // RULE_05
			`IOT_MODE_MEAS_CLR: mode_onehot = 7'h10; // RULE_05
			`IOT_MODE_MEAS_FR:  mode_onehot = 7'h20; // RULE_05
			default:            mode_onehot = 7'h40; // RULE_05
		endcase
	end

	// ==========================================
	// capture effects
	// capture stores regardless of the enable bit
	assign measure_store  = capture & (mode_onehot[4] | mode_onehot[5]); // RULE_06
	// without the enable bit the counter keeps its value
	assign counter_reload = capture & mode_onehot[4] & ext_enable; // RULE_07

endmodule // iot_chan_mode
`default_nettype wire

// ===== rtl/iot_top.v
// io timer clock, trigger and mode selection with its ahb-lite register slave
// What this block does
// RULE_01: group 0-3 clock field picks clock bus
// RULE_02: channel 4 clock field picks clock bus
// RULE_03: channel 4 enable bit gates external input
// RULE_04: channel 3/4 and 6 trigger: none, bus2, bus3
// RULE_05: three-bit mode field picks six modes
// RULE_06: measure modes store counter on any capture
// RULE_07: measure clear without enable skips reload
// RULE_08: software sets enable bit for measure clear
// RULE_09: software changes mode only when counter idle
// RULE_10: channel 5 clock: pin 1 or bus
// RULE_11: channel 5 trigger: only code 11, bus3
// RULE_12: channel 6 clock: pin 2 or bus
// RULE_13: channel 7 clock field picks clock bus
// RULE_14: channel 7 trigger: none, bus0, bus3
// RULE_15: channel 3 trigger uses channel 4 field
// RULE_16: unassigned bits read zero, ignore writes
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "iot_consts.vh"

module iot_top (
	input  wire        clock,
	input  wire        srst,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	input  wire [3:0]  clock_bus,
	input  wire [3:0]  event_bus,
	input  wire        external_clock_pin_1,
	input  wire        external_clock_pin_2,
	input  wire [3:0]  capture_pin,
	output reg  [7:0]  count_tick,
	output reg  [7:3]  trigger,
	output reg  [27:0] mode_onehot,
	output reg  [3:0]  measure_store,
	output reg  [3:0]  counter_reload
);

	// ==========================================
	// registers and bus state
	localparam SEL_NONE = 3'h0;
	localparam SEL_GRP  = 3'h1;
	localparam SEL_CH4  = 3'h2;
	localparam SEL_CH5  = 3'h3;
	localparam SEL_CH6  = 3'h4;
	localparam SEL_CH7  = 3'h5;

	reg  [7:0]  group03_clock_select_reg;
	reg  [7:0]  ch4_control_reg;
	reg  [7:0]  ch5_control_reg;
	reg  [7:0]  ch6_control_reg;
	reg  [7:0]  ch7_control_reg;
	reg         wr_pend_reg;
	reg  [2:0]  wr_sel_reg;
	reg  [7:0]  rd_next;
	reg  [7:0]  fwd_val;
	reg  [2:0]  addr_sel;
	wire        access;
	wire [31:0] addr_grp;
	wire [31:0] addr_ch4;
	wire [31:0] addr_ch5;
	wire [31:0] addr_ch6;
	wire [31:0] addr_ch7;

	assign access   = hsel & hready & htrans[1];
	assign addr_grp = {`IOT_IDX_GROUP03, 2'b00};
	assign addr_ch4 = {`IOT_IDX_CH4, 2'b00};
	assign addr_ch5 = {`IOT_IDX_CH5, 2'b00};
	assign addr_ch6 = {`IOT_IDX_CH6, 2'b00};
	assign addr_ch7 = {`IOT_IDX_CH7, 2'b00};

	// ==========================================
	// address decode, none means unmapped
	always @* begin
		if (haddr == addr_grp)
			addr_sel = SEL_GRP;
		else if (haddr == addr_ch4)
			addr_sel = SEL_CH4;
		else if (haddr == addr_ch5)
			addr_sel = SEL_CH5;
		else if (haddr == addr_ch6)
			addr_sel = SEL_CH6;
		else if (haddr == addr_ch7)
			addr_sel = SEL_CH7;
		else
			addr_sel = SEL_NONE;
	end

	// read mux; a write still in its data phase is forwarded so back to back works
	always @* begin
		case (addr_sel)
			SEL_GRP: rd_next = group03_clock_select_reg;
			SEL_CH4: rd_next = ch4_control_reg;
			SEL_CH5: rd_next = ch5_control_reg;
			SEL_CH6: rd_next = ch6_control_reg;
			SEL_CH7: rd_next = ch7_control_reg;
			default: rd_next = 8'h00;
		endcase
		case (addr_sel)
			SEL_GRP: fwd_val = hwdata[7:0] & `IOT_MASK_GROUP03;
			SEL_CH7: fwd_val = hwdata[7:0] & `IOT_MASK_CH7;
			default: fwd_val = hwdata[7:0];
		endcase
		if (wr_pend_reg && wr_sel_reg == addr_sel && addr_sel != SEL_NONE)
			rd_next = fwd_val;
	end

	// ==========================================
	// ahb-lite slave, zero wait states, always okay
	always @(posedge clock) begin
		if (srst) begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			hrdata      <= 32'h0000_0000;
			wr_pend_reg <= 1'b0;
			wr_sel_reg  <= 3'h0;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= access & hwrite;
			wr_sel_reg  <= addr_sel;
			if (access && !hwrite)
				hrdata <= {24'h00_0000, rd_next};
		end
	end

	// control registers; mode changes rely on software idling the counter first
	always @(posedge clock) begin
		if (srst) begin
			group03_clock_select_reg <= `IOT_RESET_VAL;
			ch4_control_reg          <= `IOT_RESET_VAL;
			ch5_control_reg          <= `IOT_RESET_VAL;
			ch6_control_reg          <= `IOT_RESET_VAL;
			ch7_control_reg          <= `IOT_RESET_VAL;
		end else if (wr_pend_reg) begin
			case (wr_sel_reg)
				SEL_GRP: group03_clock_select_reg <= hwdata[7:0] & `IOT_MASK_GROUP03; // RULE_16
				SEL_CH4: ch4_control_reg <= hwdata[7:0] & `IOT_MASK_CH4;
				SEL_CH5: ch5_control_reg <= hwdata[7:0] & `IOT_MASK_CH5;
				SEL_CH6: ch6_control_reg <= hwdata[7:0] & `IOT_MASK_CH6;
				SEL_CH7: ch7_control_reg <= hwdata[7:0] & `IOT_MASK_CH7; // RULE_16
				default: ;
			endcase
		end
	end

	// ==========================================
	// pin synchronisers and rising edge detect
	reg  [5:0] pin_meta_reg;
	reg  [5:0] pin_sync_reg;
	reg  [5:0] pin_last_reg;
	wire [5:0] pin_rise;

	always @(posedge clock) begin
		if (srst) begin
			pin_meta_reg <= 6'h00;
			pin_sync_reg <= 6'h00;
			pin_last_reg <= 6'h00;
		end else begin
			pin_meta_reg <= {capture_pin, external_clock_pin_2, external_clock_pin_1};
			pin_sync_reg <= pin_meta_reg;
			pin_last_reg <= pin_sync_reg;
		end
	end

	assign pin_rise = pin_sync_reg & ~pin_last_reg;

	// ==========================================
	// clock source selection
	wire [1:0] grp_cks;
	wire [1:0] ch4_cks;
	wire [2:0] ch5_cks;
	wire [2:0] ch6_cks;
	wire [1:0] ch7_cks;
	reg  [7:0] tick_next;

	assign grp_cks = group03_clock_select_reg[`IOT_GRP_CKS_HI:`IOT_GRP_CKS_LO];
	assign ch4_cks = ch4_control_reg[`IOT_CH4_CKS_HI:`IOT_CH4_CKS_LO];
	assign ch5_cks = ch5_control_reg[`IOT_CKS3_HI:`IOT_CKS3_LO];
	assign ch6_cks = ch6_control_reg[`IOT_CKS3_HI:`IOT_CKS3_LO];
	assign ch7_cks = ch7_control_reg[`IOT_CH7_CKS_HI:`IOT_CH7_CKS_LO];

	always @* begin
		tick_next[3:0] = {4{clock_bus[grp_cks]}}; // RULE_01
		tick_next[4]   = clock_bus[ch4_cks]; // RULE_02
		tick_next[7]   = clock_bus[ch7_cks]; // RULE_13
		// any code below 100 takes the pin, whatever its low bits
		case (ch5_cks)
			3'h4:    tick_next[5] = clock_bus[0]; // RULE_10
			3'h5:    tick_next[5] = clock_bus[1]; // RULE_10
			3'h6:    tick_next[5] = clock_bus[2]; // RULE_10
			3'h7:    tick_next[5] = clock_bus[3]; // RULE_10
			default: tick_next[5] = pin_rise[0]; // RULE_10
		endcase
		case (ch6_cks)
			3'h4:    tick_next[6] = clock_bus[0]; // RULE_12
			3'h5:    tick_next[6] = clock_bus[1]; // RULE_12
			3'h6:    tick_next[6] = clock_bus[2]; // RULE_12
			3'h7:    tick_next[6] = clock_bus[3]; // RULE_12
			default: tick_next[6] = pin_rise[1]; // RULE_12
		endcase
	end

	// ==========================================
	// enable/measure source selection
	wire [1:0] ch34_ens;
	wire [1:0] ch5_ens;
	wire [1:0] ch6_ens;
	wire [1:0] ch7_ens;
	wire       ch4_een;
	reg  [7:3] trig_next;
	reg        shared_trig;

	assign ch34_ens = ch4_control_reg[`IOT_ENS_HI:`IOT_ENS_LO];
	assign ch5_ens  = ch5_control_reg[`IOT_ENS_HI:`IOT_ENS_LO];
	assign ch6_ens  = ch6_control_reg[`IOT_ENS_HI:`IOT_ENS_LO];
	assign ch7_ens  = ch7_control_reg[`IOT_ENS_HI:`IOT_ENS_LO];
	assign ch4_een  = ch4_control_reg[`IOT_CH4_EEN];

	always @* begin
		// channel 3 has no field of its own
		case (ch34_ens)
			2'h2:    shared_trig = event_bus[2]; // RULE_04
			2'h3:    shared_trig = event_bus[3]; // RULE_04
			default: shared_trig = 1'b0; // RULE_04
		endcase
		trig_next[3] = shared_trig; // RULE_15
		// the enable bit gates channel 4 only, not the shared channel 3 path
		trig_next[4] = shared_trig & ch4_een; // RULE_03
		// code 10 selects nothing here, unlike channels 4 and 6
		case (ch5_ens)
			2'h3:    trig_next[5] = event_bus[3]; // RULE_11
			default: trig_next[5] = 1'b0; // RULE_11
		endcase
		case (ch6_ens)
			2'h2:    trig_next[6] = event_bus[2]; // RULE_04
			2'h3:    trig_next[6] = event_bus[3]; // RULE_04
			default: trig_next[6] = 1'b0; // RULE_04
		endcase
		case (ch7_ens)
			2'h2:    trig_next[7] = event_bus[0]; // RULE_14
			2'h3:    trig_next[7] = event_bus[3]; // RULE_14
			default: trig_next[7] = 1'b0; // RULE_14
		endcase
	end

	// ==========================================
	// per channel mode decode, channels 4 to 7
	wire [11:0] mode_all;
	wire [3:0]  een_all;
	wire [27:0] oh_all;
	wire [3:0]  store_all;
	wire [3:0]  reload_all;

	assign mode_all = {ch7_control_reg[`IOT_MODE_HI:`IOT_MODE_LO],
		ch6_control_reg[`IOT_MODE_HI:`IOT_MODE_LO],
		ch5_control_reg[`IOT_MODE_HI:`IOT_MODE_LO],
		ch4_control_reg[`IOT_MODE_HI:`IOT_MODE_LO]};
	// only channel 4 owns an enable bit here; the others reload on every measure clear capture
	assign een_all  = {3'h7, ch4_een};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
			iot_chan_mode u_mode (
				.mode           (mode_all[3*gi+2:3*gi]),
				.ext_enable     (een_all[gi]),
				.capture        (pin_rise[2+gi]),
				.mode_onehot    (oh_all[7*gi+6:7*gi]),
				.measure_store  (store_all[gi]),
				.counter_reload (reload_all[gi])
			);
		end
	endgenerate

	// ==========================================
	// registered outputs
	always @(posedge clock) begin
		if (srst) begin
			count_tick     <= 8'h00;
			trigger        <= 5'h00;
			mode_onehot    <= 28'h0000_000;
			measure_store  <= 4'h0;
			counter_reload <= 4'h0;
		end else begin
			count_tick     <= tick_next;
			trigger        <= trig_next;
			mode_onehot    <= oh_all; // RULE_05
			measure_store  <= store_all; // RULE_06
			counter_reload <= reload_all; // RULE_07
		end
	end

endmodule // iot_top
`default_nettype wire

// ===== sim/iot_checker.sv
// assertion checker for the io timer control block
`timescale 1ns/100ps
`default_nettype none
module iot_checker (
	input wire logic        clock,
	input wire logic        srst,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic [3:0]  clock_bus,
	input wire logic [3:0]  event_bus,
	input wire logic [7:0]  count_tick,
	input wire logic [7:3]  trigger,
	input wire logic [27:0] mode_onehot,
	input wire logic [3:0]  measure_store,
	input wire logic [3:0]  counter_reload
);
	default clocking dcb @(posedge clock); endclocking
	default disable iff (srst);
	// ==========================================
	// bus answer
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	AST_RDZERO: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	// ==========================================
	// selection
	AST_GROUP: assert property (clock_bus == 4'hf |=> count_tick[4:0] == 5'h1f && count_tick[7])
		else $error("bus channels miss a tick");
	AST_BUSIDLE: assert property (clock_bus == 4'h0 |=> !count_tick[4] && !count_tick[7])
		else $error("tick without clock bus activity");
	AST_NOEVENT: assert property (event_bus == 4'h0 |=> trigger == 5'h0)
		else $error("trigger without event");
	// modes register one cycle after reset, so skip that edge
	AST_ONEHOT: assert property (!$past(srst) |-> $onehot(mode_onehot[6:0]) && $onehot(mode_onehot[27:21]))
		else $error("mode decode not one hot");
	// ==========================================
	// capture effects
	AST_STORE: assert property (measure_store[0] |-> mode_onehot[4] || mode_onehot[5])
		else $error("store outside measure mode");
	AST_PULSE: assert property ($rose(measure_store[0]) |=> !measure_store[0])
		else $error("store pulse too long");
	AST_RELOAD: assert property (counter_reload[0] |-> measure_store[0] && mode_onehot[4])
		else $error("reload outside measure clear");
	COV_STORE: cover property (measure_store[0]);
	COV_RELOAD: cover property (counter_reload[1]);
	COV_TRIG: cover property (trigger[7]);
endmodule // iot_checker
`default_nettype wire

// ===== sim/tb.sv
// register and selection testbench for the io timer control block
`timescale 1ns/100ps
`default_nettype none
`include "iot_consts.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
	$display("BAD %0t %h %h", $time, (a), (e)); end end
module tb;
	logic        clock, srst, hsel, hwrite, hreadyout, hresp;
	logic        external_clock_pin_1, external_clock_pin_2;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0]  clock_bus, event_bus, capture_pin, measure_store, counter_reload, st, rl;
	logic [7:0]  count_tick, tk;
	logic [7:3]  trigger;
	logic [27:0] mode_onehot;
	int          error_cnt, compares;
	wire         hready = hreadyout;
	logic [31:0] adr [5] = '{`IOT_IDX_GROUP03 * 4, `IOT_IDX_CH4 * 4, `IOT_IDX_CH5 * 4,
		`IOT_IDX_CH6 * 4, `IOT_IDX_CH7 * 4};
	logic [31:0] msk [5] = '{32'h03, 32'hff, 32'hff, 32'hff, 32'h7f};
	iot_top iot_top_inst (
		.clock                (clock),
		.srst                 (srst),
		.hsel                 (hsel),
		.haddr                (haddr),
		.htrans               (htrans),
		.hwrite               (hwrite),
		.hsize                (hsize),
		.hwdata               (hwdata),
		.hready               (hready),
		.hreadyout            (hreadyout),
		.hrdata               (hrdata),
		.hresp                (hresp),
		.clock_bus            (clock_bus),
		.event_bus            (event_bus),
		.external_clock_pin_1 (external_clock_pin_1),
		.external_clock_pin_2 (external_clock_pin_2),
		.capture_pin          (capture_pin),
		.count_tick           (count_tick),
		.trigger              (trigger),
		.mode_onehot          (mode_onehot),
		.measure_store        (measure_store),
		.counter_reload       (counter_reload)
	);
	always #5 clock = ~clock;
	// ==========================================
	// bus and stimulus tasks
	task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= `IOT_HTRANS_NONSEQ;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [31:0] a, e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		`CHK(r, e)
	endtask
	// levels only, so one edge of slack is harmless
	task automatic sense(input logic [3:0] cb, ev);
		@(posedge clock);
		clock_bus <= cb;
		event_bus <= ev;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic pins(input logic [3:0] cap);
		@(posedge clock);
		external_clock_pin_1 <= 1'b1;
		external_clock_pin_2 <= 1'b1;
		capture_pin <= cap;
		{tk, st, rl} = '0;
		repeat (8) begin
			@(posedge clock);
			#1;
			tk |= count_tick;
			st |= measure_store;
			rl |= counter_reload;
		end
		@(posedge clock);
		external_clock_pin_1 <= 1'b0;
		external_clock_pin_2 <= 1'b0;
		capture_pin <= 4'h0;
		repeat (4) @(posedge clock);
	endtask
	function automatic logic [7:3] trig(input logic [2:0] k, input logic [3:0] e);
		logic s;
		s = k[1:0] == 2'h2 ? e[2] : k[1:0] == 2'h3 ? e[3] : 1'b0;
		return {k[1:0] == 2'h2 ? e[0] : k[1:0] == 2'h3 ? e[3] : 1'b0, s,
			k[1:0] == 2'h3 && e[3], s & k[2], s};
	endfunction
	task automatic final_report;
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial begin
		{clock, hsel, hwrite, htrans, haddr, hwdata, clock_bus, event_bus, capture_pin} = '0;
		{external_clock_pin_1, external_clock_pin_2, error_cnt, compares} = '0;
		hsize = 3'h2;
		srst = 1'b1;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		foreach (adr[i]) rd(adr[i], 32'h0);
		foreach (adr[i]) wr(adr[i], 32'hffffffff);
		foreach (adr[i]) rd(adr[i], msk[i]);
		wr(32'h02000d30, 32'hff);
		rd(32'h02000d30, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(adr[0], 32'(c));
			wr(adr[1], 32'(c << 6));
			wr(adr[2], 32'((c + 4) << 5));
			wr(adr[3], 32'((c + 4) << 5));
			wr(adr[4], 32'(c << 5));
			sense(4'h1 << c, 4'h0);
			`CHK(count_tick, 8'hff)
			sense(~(4'h1 << c), 4'h0);
			`CHK(count_tick, 8'h00)
		end
		wr(adr[2], 32'h0);
		wr(adr[3], 32'h0);
		sense(4'hf, 4'h0);
		`CHK(count_tick, 8'h9f)
		pins(4'h0);
		`CHK(tk[6:5], 2'h3)
		for (int k = 0; k < 8; k++) begin
			wr(adr[1], 32'({k[2], k[1:0], 3'h0}));
			for (int i = 2; i < 5; i++) wr(adr[i], 32'({k[1:0], 3'h0}));
			for (int e = 0; e < 16; e++) begin
				sense(4'h0, 4'(e));
				`CHK(trigger, trig(3'(k), 4'(e)))
			end
		end
		for (int m = 0; m < 8; m++) begin
			for (int i = 1; i < 5; i++) wr(adr[i], 32'(m));
			sense(4'h0, 4'h0);
			`CHK(mode_onehot, {4{m > 5 ? 7'h40 : 7'h1 << m}})
		end
		// clear mode without enable must store but never reload
		wr(adr[1], 32'h04);
		wr(adr[2], 32'h04);
		wr(adr[3], 32'h05);
		wr(adr[4], 32'h00);
		pins(4'hf);
		`CHK({st, rl}, 8'h72)
		wr(adr[1], 32'h24);
		pins(4'h1);
		`CHK({st, rl}, 8'h11)
		final_report;
	end
	initial begin
		#200000;
		error_cnt++;
		final_report;
	end
endmodule // tb
bind iot_top iot_checker iot_checker_inst (
	.clock          (clock),
	.srst           (srst),
	.hreadyout      (hreadyout),
	.hresp          (hresp),
	.hrdata         (hrdata),
	.clock_bus      (clock_bus),
	.event_bus      (event_bus),
	.count_tick     (count_tick),
	.trigger        (trigger),
	.mode_onehot    (mode_onehot),
	.measure_store  (measure_store),
	.counter_reload (counter_reload)
);
`default_nettype wire
